// >>> tcg_pkg.sv
// constants and types shared by the time code generator
package tcg_pkg;
  typedef enum logic [2:0] {
    TCG_B    = 3'h0,
    TCG_G    = 3'h1,
    TCG_H    = 3'h2,
    TCG_E    = 3'h3,
    TCG_XR3  = 3'h6,
    TCG_NASA = 3'h7
  } tcg_fmt_e;
  typedef enum logic [1:0] {
    TCG_ZERO = 2'h0,
    TCG_ONE  = 2'h1,
    TCG_PI   = 2'h3,
    TCG_NONE = 2'h2
  } tcg_kind_e;
  // base tick of the slot timer
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 10;
  localparam int CYC_PER_TICK = CLK_MHZ * TICK_US;
  localparam int TW = 17;
  // format selector codes
  localparam logic [3:0] SEL_A = 4'h0;
  localparam logic [3:0] SEL_B = 4'h1;
  localparam logic [3:0] SEL_G = 4'h2;
  localparam logic [3:0] SEL_E1 = 4'h3;
  localparam logic [3:0] SEL_E2 = 4'h4;
  localparam logic [3:0] SEL_H1 = 4'h5;
  localparam logic [3:0] SEL_H2 = 4'h6;
  localparam logic [3:0] SEL_XR3 = 4'h7;
  localparam logic [3:0] SEL_2137 = 4'h8;
  localparam logic [3:0] SEL_NASA = 4'h9;
  // slot periods and pulse widths in microseconds
  localparam int B_PERIOD_US = 10000;
  localparam int B_ZERO_US = 2000;
  localparam int B_ONE_US = 5000;
  localparam int B_PI_US = 8000;
  localparam int G_PERIOD_US = 100;
  localparam int G_ZERO_US = 20;
  localparam int G_ONE_US = 50;
  localparam int G_PI_US = 80;
  localparam int E_PERIOD_US = 100000;
  localparam int E_ZERO_US = 20000;
  localparam int E_ONE_US = 50000;
  localparam int E_PI_US = 80000;
  localparam int H_PERIOD_US = 1000000;
  localparam int H_ZERO_US = 200000;
  localparam int H_ONE_US = 500000;
  localparam int H_PI_US = 800000;
  localparam int X_PERIOD_US = 40000;
  localparam int X_ZERO_US = 12000;
  localparam int X_ONE_US = 24000;
  localparam int X_REF_US = 36000;
  // frame layout
  localparam logic [6:0] IRIG_LEN = 7'd100;
  localparam logic [6:0] H_LEN = 7'd60;
  localparam logic [6:0] X_LEN = 7'd25;
  localparam logic [6:0] X_DATA_END = 7'd20;
  localparam int SEC_IDX = 1;
  localparam int E_SEC_IDX = 6;
  localparam int MIN_IDX = 10;
  localparam int HR_IDX = 20;
  localparam int DAY_IDX = 30;
  localparam int DAY_HUN_IDX = 40;
  localparam int FRAC_T_IDX = 45;
  localparam int FRAC_H_IDX = 50;
  localparam int SBS_IDX = 80;
  localparam int SBS_HI_IDX = 90;
  localparam logic [16:0] SBS_MAX = 17'd86399;
  localparam logic [3:0] BCD_NINE = 4'h9;

  function automatic logic [TW-1:0] to_ticks(input int us);
    return TW'(us / TICK_US);
  endfunction
endpackage

// >>> tcg_slot_timer.sv
// slot timer: base tick prescaler, slot counter and pulse shaper
`timescale 1ns/1ps
module tcg_slot_timer #(
  parameter int CYC_PER_TICK = tcg_pkg::CYC_PER_TICK,
  parameter int TW = tcg_pkg::TW
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [TW-1:0] i_period,
  input wire logic [TW-1:0] i_width,
  input wire logic i_trail,
  output logic o_slot_end,
  output logic o_level
);
  localparam int PW = $clog2(CYC_PER_TICK + 1);

  // one-cycle ticks would leave the restarted count visible for one edge
  if (CYC_PER_TICK < 2) begin : g_chk
    $error("tick prescale must be at least two cycles");
  end

  logic [PW-1:0] pre_q;
  logic [TW-1:0] cnt_q;
  logic tick;

  assign tick = (pre_q == PW'(CYC_PER_TICK - 1));
  assign o_slot_end = tick && (cnt_q == i_period - 1'b1);
  // trailing reference: pulse pushed to the end of its slot
  assign o_level = i_trail ? (cnt_q >= i_period - i_width)
                           : (cnt_q < i_width);

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start) begin
      cnt_q <= '0;
    end else if (o_slot_end) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  lead_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_trail && cnt_q == '0 && i_width != '0 |-> o_level)
    else $error("leading pulse not high at slot start");
  cnt_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_slot_end) |=> (cnt_q == '0) [*2])
    else $error("slot counter did not restart");
endmodule // tcg_slot_timer

// >>> tcg_gen.sv
// multi-format serial time code generator top
//
// What this block does
// - B frame: 1 s, 30 BCD, 17 binary
// - binary word at 80, marker after ninth
// - seconds-of-day counts up, wraps after 86399
// - B: 100 elements, 10 markers, 1 frame/s
// - B widths 2, 5, 8 ms
// - reference is two markers, second on-time
// - B BCD from index 1, groups, LSD first
// - separator element between digits of group
// - IRIG reference at pulse leading edge
// - G frame 10 ms, adds fractional digits
// - G fractional digits follow the days
// - G: 10000 elements, 1000 markers, 100 frames
// - G widths 0.02, 0.05, 0.08 ms
// - E frame 10 s, seconds 3 bits, index 6
// - E: 10 elements/s, marker rate 1/s
// - E widths 20, 50, 80 ms
// - H frame 1 min, minutes from index 10
// - H widths 0.2, 0.5, 0.8 s
// - XR3/2137: 25 slots, last four empty
// - XR3/2137 widths 12, 24, 36 ms
// - XR3/2137 reference at pulse trailing edge
// - NASA: 1 s frame, 100 elements, 30 BCD
// - NASA separates digits with a one
// - one-digit (4-bit) selector picks the format
// - IRIG B after reset until selected
`timescale 1ns/1ps
module tcg_gen #(
  parameter int CYC_PER_TICK = tcg_pkg::CYC_PER_TICK
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pps,
  input wire logic [3:0] i_fmt_sel,
  input wire logic i_fmt_wr,
  input wire logic i_time_wr,
  input wire logic [16:0] i_sbs,
  input wire logic [11:0] i_day_bcd,
  input wire logic [7:0] i_hour_bcd,
  input wire logic [7:0] i_min_bcd,
  input wire logic [7:0] i_sec_bcd,
  output logic o_code,
  output logic o_on_time,
  output logic o_active,
  output logic [2:0] o_fmt
);
  localparam int TW = tcg_pkg::TW;

  tcg_pkg::tcg_fmt_e fmt_q, fmt_pend_q;
  logic pps_m_q, pps_s_q, pps_d_q;
  logic [16:0] sbs_q, sbs_d;
  logic [7:0] sec_q, min_q, hr_q, frac_q, frac_inc;
  logic [11:0] day_q;
  logic [99:0] vec_q;
  logic [6:0] idx_q, len;
  logic run_q, mark_q, pps_rise, frame_go, wrap, boundary, mark;
  logic slot_end, level, sel_ok;
  tcg_pkg::tcg_fmt_e sel_fmt;
  tcg_pkg::tcg_kind_e kind;
  logic [TW-1:0] period, width;

  always_comb begin
    sel_ok = 1'b1;
    sel_fmt = tcg_pkg::TCG_B;
    case (i_fmt_sel)
      tcg_pkg::SEL_B: sel_fmt = tcg_pkg::TCG_B;
      tcg_pkg::SEL_G: sel_fmt = tcg_pkg::TCG_G;
      tcg_pkg::SEL_E1, tcg_pkg::SEL_E2: sel_fmt = tcg_pkg::TCG_E;
      tcg_pkg::SEL_H1, tcg_pkg::SEL_H2: sel_fmt = tcg_pkg::TCG_H;
      tcg_pkg::SEL_XR3, tcg_pkg::SEL_2137: sel_fmt = tcg_pkg::TCG_XR3;
      tcg_pkg::SEL_NASA: sel_fmt = tcg_pkg::TCG_NASA;
      // format A has no generator here; the selection is ignored
      default: sel_ok = 1'b0;
    endcase
  end

  function automatic logic [6:0] frame_len(input tcg_pkg::tcg_fmt_e f);
    case (f)
      tcg_pkg::TCG_H: return tcg_pkg::H_LEN;
      tcg_pkg::TCG_XR3: return tcg_pkg::X_LEN;
      default: return tcg_pkg::IRIG_LEN;
    endcase
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] != tcg_pkg::BCD_NINE) begin
      r[3:0] = v[3:0] + 4'h1;
    end else begin
      r[3:0] = 4'h0;
      r[7:4] = (v[7:4] == tcg_pkg::BCD_NINE) ? 4'h0 : v[7:4] + 4'h1;
    end
    return r;
  endfunction

  // places the code word; marker slots are overridden by the kind
  function automatic logic [99:0] build(input tcg_pkg::tcg_fmt_e f,
      input logic [7:0] s, input logic [7:0] m, input logic [7:0] h,
      input logic [11:0] d, input logic [7:0] fr, input logic [16:0] b);
    logic [99:0] v;
    logic sep;
    v = '0;
    sep = (f == tcg_pkg::TCG_NASA);
    if (f == tcg_pkg::TCG_XR3) begin
      v[1 +: 4] = h[3:0];
      v[5 +: 2] = h[5:4];
      v[7 +: 4] = m[3:0];
      v[11 +: 3] = m[6:4];
      v[14 +: 4] = s[3:0];
      v[18 +: 3] = s[6:4];
    end else begin
      if (f == tcg_pkg::TCG_E) begin
        v[tcg_pkg::E_SEC_IDX +: 3] = s[6:4];
      end else if (f != tcg_pkg::TCG_H) begin
        v[tcg_pkg::SEC_IDX +: 4] = s[3:0];
        v[tcg_pkg::SEC_IDX + 4] = sep;
        v[tcg_pkg::SEC_IDX + 5 +: 3] = s[6:4];
      end
      v[tcg_pkg::MIN_IDX +: 4] = m[3:0];
      v[tcg_pkg::MIN_IDX + 4] = sep;
      v[tcg_pkg::MIN_IDX + 5 +: 3] = m[6:4];
      v[tcg_pkg::HR_IDX +: 4] = h[3:0];
      v[tcg_pkg::HR_IDX + 4] = sep;
      v[tcg_pkg::HR_IDX + 5 +: 2] = h[5:4];
      v[tcg_pkg::DAY_IDX +: 4] = d[3:0];
      v[tcg_pkg::DAY_IDX + 4] = sep;
      v[tcg_pkg::DAY_IDX + 5 +: 4] = d[7:4];
      v[tcg_pkg::DAY_HUN_IDX +: 2] = d[9:8];
      if (f == tcg_pkg::TCG_G) begin
        v[tcg_pkg::FRAC_T_IDX +: 4] = fr[7:4];
        v[tcg_pkg::FRAC_H_IDX +: 4] = fr[3:0];
      end
      if (f == tcg_pkg::TCG_B) begin
        v[tcg_pkg::SBS_IDX +: 9] = b[8:0];
        v[tcg_pkg::SBS_HI_IDX +: 8] = b[16:9];
      end
    end
    return v;
  endfunction

  always_comb begin
    kind = vec_q[idx_q] ? tcg_pkg::TCG_ONE : tcg_pkg::TCG_ZERO;
    if (fmt_q == tcg_pkg::TCG_XR3) begin
      if (idx_q == 7'd0) begin
        kind = tcg_pkg::TCG_PI;
      end else if (idx_q > tcg_pkg::X_DATA_END) begin
        kind = tcg_pkg::TCG_NONE;
      end
    end else if (idx_q == 7'd0 || idx_q % 7'd10 == 7'd9) begin
      kind = tcg_pkg::TCG_PI;
    end
  end

  always_comb begin
    period = tcg_pkg::to_ticks(tcg_pkg::B_PERIOD_US);
    width = '0;
    case (fmt_q)
      tcg_pkg::TCG_G: begin
        period = tcg_pkg::to_ticks(tcg_pkg::G_PERIOD_US);
        width = tcg_pkg::to_ticks(kind == tcg_pkg::TCG_PI ? tcg_pkg::G_PI_US
          : kind == tcg_pkg::TCG_ONE ? tcg_pkg::G_ONE_US : tcg_pkg::G_ZERO_US);
      end
      tcg_pkg::TCG_E: begin
        period = tcg_pkg::to_ticks(tcg_pkg::E_PERIOD_US);
        width = tcg_pkg::to_ticks(kind == tcg_pkg::TCG_PI ? tcg_pkg::E_PI_US
          : kind == tcg_pkg::TCG_ONE ? tcg_pkg::E_ONE_US : tcg_pkg::E_ZERO_US);
      end
      tcg_pkg::TCG_H: begin
        period = tcg_pkg::to_ticks(tcg_pkg::H_PERIOD_US);
        width = tcg_pkg::to_ticks(kind == tcg_pkg::TCG_PI ? tcg_pkg::H_PI_US
          : kind == tcg_pkg::TCG_ONE ? tcg_pkg::H_ONE_US : tcg_pkg::H_ZERO_US);
      end
      tcg_pkg::TCG_XR3: begin
        period = tcg_pkg::to_ticks(tcg_pkg::X_PERIOD_US);
        width = (kind == tcg_pkg::TCG_NONE) ? '0 : tcg_pkg::to_ticks(
          kind == tcg_pkg::TCG_PI ? tcg_pkg::X_REF_US
          : kind == tcg_pkg::TCG_ONE ? tcg_pkg::X_ONE_US : tcg_pkg::X_ZERO_US);
      end
      default: begin
        width = tcg_pkg::to_ticks(kind == tcg_pkg::TCG_PI ? tcg_pkg::B_PI_US
          : kind == tcg_pkg::TCG_ONE ? tcg_pkg::B_ONE_US : tcg_pkg::B_ZERO_US);
      end
    endcase
  end

  tcg_slot_timer #(
    .CYC_PER_TICK(CYC_PER_TICK),
    .TW(TW)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(frame_go),
    .i_period(period),
    .i_width(width),
    .i_trail(fmt_q == tcg_pkg::TCG_XR3),
    .o_slot_end(slot_end),
    .o_level(level)
  );

  // tick arrives from a pin, so two flops before use
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pps_m_q <= 1'b0;
      pps_s_q <= 1'b0;
      pps_d_q <= 1'b0;
    end else begin
      pps_m_q <= i_pps;
      pps_s_q <= pps_m_q;
      pps_d_q <= pps_s_q;
    end
  end

  assign pps_rise = pps_s_q && !pps_d_q;
  // long frames restart only on their own second boundary
  assign boundary = (fmt_pend_q == tcg_pkg::TCG_H) ? (i_sec_bcd == 8'h00)
    : (fmt_pend_q == tcg_pkg::TCG_E) ? (i_sec_bcd[3:0] == 4'h0) : 1'b1;
  assign frame_go = pps_rise && boundary;
  assign len = frame_len(fmt_q);
  assign wrap = run_q && slot_end && (idx_q == len - 7'd1);
  assign frac_inc = bcd_inc(frac_q);
  assign mark = frame_go ? (fmt_pend_q != tcg_pkg::TCG_XR3)
    : (fmt_q == tcg_pkg::TCG_XR3) ? (run_q && slot_end && idx_q == 7'd0)
    : wrap;

  always_comb begin
    sbs_d = sbs_q;
    if (i_time_wr) begin
      sbs_d = i_sbs;
    end else if (pps_rise) begin
      sbs_d = (sbs_q == tcg_pkg::SBS_MAX) ? '0 : sbs_q + 17'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sbs_q <= '0;
    end else begin
      sbs_q <= sbs_d;
    end
  end

  // a new format waits for the next frame_go, which restarts even a frame still running
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fmt_pend_q <= tcg_pkg::TCG_B;
      fmt_q <= tcg_pkg::TCG_B;
    end else begin
      if (i_fmt_wr && sel_ok) begin
        fmt_pend_q <= sel_fmt;
      end
      if (frame_go) begin
        fmt_q <= fmt_pend_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sec_q <= '0;
      min_q <= '0;
      hr_q <= '0;
      day_q <= '0;
    end else if (frame_go) begin
      sec_q <= i_sec_bcd;
      min_q <= i_min_bcd;
      hr_q <= i_hour_bcd;
      day_q <= i_day_bcd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || frame_go) begin
      frac_q <= '0;
    end else if (wrap) begin
      frac_q <= frac_inc;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_q <= 1'b0;
      idx_q <= '0;
      vec_q <= '0;
    end else if (frame_go) begin
      run_q <= 1'b1;
      idx_q <= '0;
      vec_q <= build(fmt_pend_q, i_sec_bcd, i_min_bcd, i_hour_bcd,
        i_day_bcd, 8'h00, sbs_d);
    end else if (wrap) begin
      idx_q <= '0;
      vec_q <= build(fmt_q, sec_q, min_q, hr_q, day_q, frac_inc, sbs_q);
    end else if (run_q && slot_end) begin
      idx_q <= idx_q + 7'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mark_q <= 1'b0;
      o_on_time <= 1'b0;
      o_code <= 1'b0;
      o_active <= 1'b0;
      o_fmt <= tcg_pkg::TCG_B;
    end else begin
      mark_q <= mark;
      o_on_time <= mark_q;
      o_code <= run_q && level;
      o_active <= run_q;
      o_fmt <= fmt_q;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sbs_wrap_a: assert property (
    pps_rise && !i_time_wr && sbs_q == tcg_pkg::SBS_MAX |=> sbs_q == '0)
    else $error("seconds of day did not wrap");
  sbs_step_a: assert property (
    pps_rise && !i_time_wr && sbs_q != tcg_pkg::SBS_MAX
    |=> sbs_q == $past(sbs_q) + 17'd1)
    else $error("seconds of day did not step");
  idx_range_a: assert property (
    idx_q < frame_len(fmt_q))
    else $error("element index beyond frame");
  ref_pair_a: assert property (
    run_q && fmt_q != tcg_pkg::TCG_XR3 && idx_q == len - 7'd1 && slot_end
    && !frame_go |=> kind == tcg_pkg::TCG_PI && idx_q == '0)
    else $error("reference not two markers");
  xr3_gap_a: assert property (
    fmt_q == tcg_pkg::TCG_XR3 && idx_q > tcg_pkg::X_DATA_END && !frame_go
    |-> ##2 !o_code)
    else $error("pulse in empty slot");
  b_width_a: assert property (
    fmt_q == tcg_pkg::TCG_B && kind == tcg_pkg::TCG_ONE
    |-> width == tcg_pkg::to_ticks(tcg_pkg::B_ONE_US))
    else $error("one pulse width wrong");
  fmt_reset_a: assert property (
    $past(i_rst) |-> fmt_q == tcg_pkg::TCG_B && fmt_pend_q == tcg_pkg::TCG_B)
    else $error("format not B after reset");
  on_time_a: assert property (
    frame_go && fmt_pend_q != tcg_pkg::TCG_XR3 |-> ##2 o_on_time && o_code)
    else $error("on-time mark not on frame start");
  frac_a: assert property (
    frac_q[3:0] <= tcg_pkg::BCD_NINE && frac_q[7:4] <= tcg_pkg::BCD_NINE)
    else $error("fraction digits not decimal");
endmodule // tcg_gen

// >>> tcg_rx_model.sv
// receiving equipment model: measures each element of the dc time code
`timescale 1ns/1ps
module tcg_rx_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_code,
  input wire logic i_on_time,
  output logic o_done,
  output logic [31:0] o_width,
  output logic [31:0] o_period,
  output logic o_ref_rise,
  output logic o_ref_fall
);
  logic code_q;
  logic rise_ref_q;
  logic [31:0] hi_cnt_q;
  logic [31:0] per_cnt_q;

  // passive listener: it drives nothing back, so it cannot mask a fault
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      code_q <= 1'b0;
      rise_ref_q <= 1'b0;
      hi_cnt_q <= 32'h0;
      per_cnt_q <= 32'h0;
      o_done <= 1'b0;
      o_width <= 32'h0;
      o_period <= 32'h0;
      o_ref_rise <= 1'b0;
      o_ref_fall <= 1'b0;
    end else begin
      code_q <= i_code;
      o_done <= 1'b0;
      hi_cnt_q <= hi_cnt_q + 32'h1;
      per_cnt_q <= per_cnt_q + 32'h1;
      // element period measured leading edge to leading edge
      if (i_code && !code_q) begin
        o_period <= per_cnt_q;
        per_cnt_q <= 32'h1;
        hi_cnt_q <= 32'h1;
        rise_ref_q <= i_on_time;
      end
      if (!i_code && code_q) begin
        o_done <= 1'b1;
        o_width <= hi_cnt_q;
        o_ref_rise <= rise_ref_q;
        o_ref_fall <= i_on_time;
      end
    end
  end
endmodule // tcg_rx_model

// >>> tcg_gen_test.sv
// self-checking testbench of the time code generator
`timescale 1ns/1ps
module tcg_gen_test;
  // short prescaler keeps whole frames of the fast formats in reach
  localparam int CPT = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pps = 1'b0;
  logic [3:0] fmt_sel = 4'h0;
  logic fmt_wr = 1'b0;
  logic time_wr = 1'b0;
  logic [16:0] sbs = 17'h0;
  logic [11:0] day = 12'h0;
  logic [7:0] hour = 8'h0;
  logic [7:0] minute = 8'h0;
  logic [7:0] sec = 8'h0;
  logic code, on_time, active;
  logic [2:0] fmt;
  logic rx_done, rx_rr, rx_rf;
  logic [31:0] rx_w, rx_p;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int frac = 0;
  logic [3:0] codes [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  logic [2:0] exps [5] = '{3'h3, 3'h3, 3'h2, 3'h2, 3'h6};

  always #2.5 clk = ~clk;

  tcg_gen #(.CYC_PER_TICK(CPT)) dut (.i_clk(clk), .i_rst(rst), .i_pps(pps),
    .i_fmt_sel(fmt_sel), .i_fmt_wr(fmt_wr), .i_time_wr(time_wr),
    .i_sbs(sbs), .i_day_bcd(day), .i_hour_bcd(hour), .i_min_bcd(minute),
    .i_sec_bcd(sec), .o_code(code), .o_on_time(on_time),
    .o_active(active), .o_fmt(fmt));

  tcg_rx_model rx (.i_clk(clk), .i_rst(rst), .i_code(code),
    .i_on_time(on_time), .o_done(rx_done), .o_width(rx_w),
    .o_period(rx_p), .o_ref_rise(rx_rr), .o_ref_fall(rx_rf));

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fail(input string m);
    fails++;
    $display("CHECK FAILED at %0t ns: %s", $time, m);
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) fail(m);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 100000) begin
      fail("run too long");
      stop_test();
    end
  end

  // f: 1 g, 6 xr3, else b and nasa; k: 0 zero, 1 one, 2 marker, 3 period
  function automatic int w_exp(input int f, input int k);
    int us;
    case (f)
      1: us = k == 0 ? tcg_pkg::G_ZERO_US : k == 1 ? tcg_pkg::G_ONE_US :
              k == 2 ? tcg_pkg::G_PI_US : tcg_pkg::G_PERIOD_US;
      6: us = k == 0 ? tcg_pkg::X_ZERO_US : k == 1 ? tcg_pkg::X_ONE_US :
              k == 2 ? tcg_pkg::X_REF_US : tcg_pkg::X_PERIOD_US;
      default: us = k == 0 ? tcg_pkg::B_ZERO_US : k == 1 ? tcg_pkg::B_ONE_US :
              k == 2 ? tcg_pkg::B_PI_US : tcg_pkg::B_PERIOD_US;
    endcase
    return us / tcg_pkg::TICK_US * CPT;
  endfunction

  // element kind by index; f 7 is nasa, whose digit separators are ones
  function automatic int kind_of(input int f, input int i);
    logic [3:0] t, h;
    t = 4'(frac / 10);
    h = 4'(frac % 10);
    if (i == 0 || i % 10 == 9) return 2;
    if (i == 5 || i == 14 || i == 24 || i == 34) return int'(f == 7);
    if (i <= 4) return int'(sec[i-1]);
    if (i <= 8) return int'(sec[i-2]);
    if (i >= 10 && i <= 13) return int'(minute[i-10]);
    if (i >= 15 && i <= 17) return int'(minute[i-11]);
    if (i >= 20 && i <= 23) return int'(hour[i-20]);
    if (i >= 25 && i <= 26) return int'(hour[i-21]);
    if (i >= 30 && i <= 33) return int'(day[i-30]);
    if (i >= 35 && i <= 38) return int'(day[i-31]);
    if (i >= 40 && i <= 41) return int'(day[i-32]);
    if (f == 1 && i >= 45 && i <= 48) return int'(t[i-45]);
    if (f == 1 && i >= 50 && i <= 53) return int'(h[i-50]);
    return 0;
  endfunction

  task automatic new_time();
    sec = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
    minute = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
    hour = {2'b00, 2'($urandom % 2), 4'($urandom % 10)};
    day = {4'($urandom % 3), 4'($urandom % 10), 4'($urandom % 10)};
  endtask

  task automatic pulse_fmt(input logic [3:0] s);
    @(negedge clk);
    fmt_sel = s;
    fmt_wr = 1'b1;
    @(negedge clk);
    fmt_wr = 1'b0;
  endtask

  task automatic load_time(input logic [16:0] v);
    @(negedge clk);
    sbs = v;
    time_wr = 1'b1;
    @(negedge clk);
    time_wr = 1'b0;
  endtask

  task automatic tick();
    @(negedge clk);
    pps = 1'b1;
    repeat (3) @(negedge clk);
    pps = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic get_elem();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rx_done !== 1'b1 && n < 20000);
    if (n >= 20000) fail("no element seen");
  endtask

  // sync: skip elements cut by the tick until the on-time element
  task automatic run_frame(input int f, input int n, input bit sync);
    int i;
    i = 0;
    if (sync) begin
      do begin
        get_elem();
        i++;
      end while (rx_rr !== 1'b1 && i < 6);
    end else get_elem();
    for (i = 0; i < n; i++) begin
      if (i > 0) get_elem();
      chk(rx_w === w_exp(f, kind_of(f, i)), "element width");
      chk(rx_rr === (i == 0), "on-time mark");
      if (i > 0 || !sync) chk(rx_p === w_exp(f, 3), "element period");
    end
  endtask

  initial begin
    int i, n;
    logic [31:0] seed;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(fmt === tcg_pkg::TCG_B && active === 1'b0, "reset state");
    chk(code === 1'b0, "idle before tick");
    seed = $urandom(32'h3d59);
    new_time();
    load_time(17'($urandom % 86400));
    load_time(tcg_pkg::SBS_MAX);
    tick();
    run_frame(0, 11, 1'b1);
    chk(fmt === tcg_pkg::TCG_B && active === 1'b1, "default format");
    // last valid code before the tick wins, refused codes change nothing
    new_time();
    pulse_fmt(4'h2);
    pulse_fmt(4'h0);
    pulse_fmt(4'hb);
    frac = 0;
    tick();
    run_frame(1, 100, 1'b1);
    chk(fmt === tcg_pkg::TCG_G, "g selected");
    frac = 1;
    run_frame(1, 100, 1'b0);
    // e and h only start on a whole ten seconds and minute
    sec = 8'h00;
    for (i = 0; i < 5; i++) begin
      pulse_fmt(codes[i]);
      tick();
      n = 0;
      while (fmt !== exps[i] && n < 20) begin
        @(negedge clk);
        n++;
      end
      chk(fmt === exps[i], "selector table");
    end
    new_time();
    pulse_fmt(4'h9);
    tick();
    run_frame(7, 11, 1'b1);
    chk(fmt === tcg_pkg::TCG_NASA, "nasa selected");
    new_time();
    pulse_fmt(4'h7);
    tick();
    i = 0;
    do begin
      get_elem();
      i++;
    end while (rx_rf !== 1'b1 && i < 6);
    chk(rx_rf === 1'b1, "on-time with reference fall");
    chk(rx_w === w_exp(6, 2), "reference width");
    chk(rx_rr === 1'b0, "on-time at trailing edge");
    get_elem();
    chk(rx_w === w_exp(6, int'(hour[0])), "first hour bit");
    // pulses sit at slot ends, so rise to rise is period minus width change
    chk(rx_p === w_exp(6, 3) - w_exp(6, int'(hour[0])) + w_exp(6, 2),
      "slot period");
    stop_test();
  end
endmodule // tcg_gen_test
